// [common/pcpm_pkg.sv]
// Package for the port configuration preload map.
// Assumes one 50 MHz clock and a 16-bit preload word source.
`default_nettype none
package pcpm_pkg;
  localparam int          NUM_PORTS      = 6;
  localparam int          PM_WORDS       = 2;
  localparam int          NUM_WORDS      = 18;
  localparam int          SLOT_IDX_BASE  = 12;
  localparam logic [7:0]  PM_BASE_ADDR   = 8'h50;
  localparam logic [7:0]  SLOT_BASE_ADDR = 8'h60;
  localparam logic [7:0]  SLOT_STRIDE    = 8'h02;
  localparam int          READ_LATENCY   = 2;

  // Configuration offsets
  localparam logic [11:0] OFS_PM_CAP     = 12'h040;
  localparam logic [11:0] OFS_PM_CTRL    = 12'h044;
  localparam logic [11:0] OFS_PORT_NUM   = 12'h0cc;
  localparam logic [11:0] OFS_SLOT_CLK   = 12'h0d0;
  localparam logic [11:0] OFS_LPC_GROUP  = 12'h144;
  localparam logic [11:0] OFS_VC0_MAP    = 12'h154;

  // Field positions: source bit in the word, destination bit
  localparam int PM_NSR_SRC  = 0;
  localparam int PM_NSR_DST  = 3;
  localparam int PM_AUX_SRC  = 1;
  localparam int PM_AUX_DST  = 22;
  localparam int PM_AUX_W    = 3;
  localparam int PM_D1_SRC   = 4;
  localparam int PM_D1_DST   = 25;
  localparam int PM_D2_SRC   = 5;
  localparam int PM_D2_DST   = 26;
  localparam int PM_WAKE_SRC = 6;
  localparam int PM_WAKE_DST = 28;
  localparam int PM_WAKE_W   = 2;
  localparam int PM_DATA_SRC = 8;
  localparam int PM_DATA_DST = 24;
  localparam int PM_DATA_W   = 8;
  localparam int SL_CLK_SRC  = 1;
  localparam int SL_CLK_DST  = 28;
  localparam int SL_DSI_SRC  = 2;
  localparam int SL_DSI_DST  = 21;
  localparam int SL_LPC_SRC  = 3;
  localparam int SL_LPC_DST  = 4;
  localparam int SL_PNUM_SRC = 4;
  localparam int SL_PNUM_DST = 24;
  localparam int SL_PNUM_W   = 3;
  localparam int SL_TC_SRC   = 9;
  localparam int SL_TC_DST   = 1;
  localparam int SL_TC_W     = 7;

  // Values kept when a word is absent
  localparam logic [15:0] PM_WORD0_RESET = 16'h0000;
  localparam logic [15:0] PM_WORD1_RESET = 16'h0000;
  localparam logic [15:0] SLOT_WORD_RESET = 16'h0000;

  typedef enum logic [1:0] {
    PCPM_IDLE = 2'b00,
    PCPM_LOAD = 2'b01,
    PCPM_DONE = 2'b10
  } pcpm_state_t;
endpackage
`default_nettype wire

// [hw/pcpm_word_mem.sv]
// Small word store for the loaded preload words.
// Assumes one clock; read data is registered, contents have no reset.
`default_nettype none
module pcpm_word_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 18
) (
  // Clock
  input  wire logic                     mclk,
  // Write side
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]         wrData,
  // Read sides
  input  wire logic [$clog2(DEPTH)-1:0] rdAddrA,
  input  wire logic [$clog2(DEPTH)-1:0] rdAddrB,
  output logic      [WIDTH-1:0]         rdDataA,
  output logic      [WIDTH-1:0]         rdDataB
);
  if (WIDTH < 1 || DEPTH < 2) begin : g_chk
    $error("pcpm_word_mem: bad WIDTH or DEPTH");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  // Unwritten words read unknown; the caller masks them
  always_ff @(posedge mclk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdDataA <= mem[rdAddrA];
    rdDataB <= mem[rdAddrB];
  end
endmodule
`default_nettype wire

// [hw/pcpm_field_map.sv]
// Maps preload words onto configuration register images.
// Pure combinational; the caller registers the result.
`default_nettype none
module pcpm_field_map (
  // Request
  input  wire logic [11:0] offset,
  // Words: power word 0, and power word 1 or slot word
  input  wire logic [15:0] word0,
  input  wire logic [15:0] wordB,
  // Result
  output logic      [31:0] value,
  output logic             hit
);
  always_comb begin
    value = 32'h0000_0000;
    hit   = 1'b1;
    if (offset == pcpm_pkg::OFS_PM_CAP) begin
      value[pcpm_pkg::PM_AUX_DST +: pcpm_pkg::PM_AUX_W] =
        word0[pcpm_pkg::PM_AUX_SRC +: pcpm_pkg::PM_AUX_W];
      value[pcpm_pkg::PM_D1_DST] = word0[pcpm_pkg::PM_D1_SRC];
      value[pcpm_pkg::PM_D2_DST] = word0[pcpm_pkg::PM_D2_SRC];
      value[pcpm_pkg::PM_WAKE_DST +: pcpm_pkg::PM_WAKE_W] =
        word0[pcpm_pkg::PM_WAKE_SRC +: pcpm_pkg::PM_WAKE_W];
      value[pcpm_pkg::SL_DSI_DST] = wordB[pcpm_pkg::SL_DSI_SRC];
    end else if (offset == pcpm_pkg::OFS_PM_CTRL) begin
      value[pcpm_pkg::PM_NSR_DST] = word0[pcpm_pkg::PM_NSR_SRC];
      value[pcpm_pkg::PM_DATA_DST +: pcpm_pkg::PM_DATA_W] =
        wordB[pcpm_pkg::PM_DATA_SRC +: pcpm_pkg::PM_DATA_W];
    end else if (offset == pcpm_pkg::OFS_SLOT_CLK) begin
      value[pcpm_pkg::SL_CLK_DST] = wordB[pcpm_pkg::SL_CLK_SRC];
    end else if (offset == pcpm_pkg::OFS_LPC_GROUP) begin
      value[pcpm_pkg::SL_LPC_DST] = wordB[pcpm_pkg::SL_LPC_SRC];
    end else if (offset == pcpm_pkg::OFS_PORT_NUM) begin
      value[pcpm_pkg::SL_PNUM_DST +: pcpm_pkg::SL_PNUM_W] =
        wordB[pcpm_pkg::SL_PNUM_SRC +: pcpm_pkg::SL_PNUM_W];
    end else if (offset == pcpm_pkg::OFS_VC0_MAP) begin
      value[pcpm_pkg::SL_TC_DST +: pcpm_pkg::SL_TC_W] =
        wordB[pcpm_pkg::SL_TC_SRC +: pcpm_pkg::SL_TC_W];
    end else begin
      hit = 1'b0;
    end
  end
endmodule
`default_nettype wire

// [hw/pcpm_loader.sv]
// Preload loader and configuration read port for six switch ports.
// Assumes a same-clock preload source that acks each word request.
`default_nettype none
module pcpm_loader (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Preload source
  output logic             pldReq,
  output logic [7:0]       pldAddr,
  input  wire logic        pldAck,
  input  wire logic [15:0] pldData,
  input  wire logic        pldPresent,
  // Configuration reads
  input  wire logic        cfgRdEn,
  input  wire logic [2:0]  cfgPort,
  input  wire logic [11:0] cfgOffset,
  output logic             cfgRdValid,
  output logic [31:0]      cfgRdData,
  output logic             cfgRdHit,
  // Status
  output logic             loadDone
);
  localparam int          IW       = $clog2(pcpm_pkg::NUM_WORDS);
  localparam logic [IW-1:0] LAST_IDX =
    IW'(pcpm_pkg::NUM_WORDS - 1);
  localparam logic [IW-1:0] SLOT_IDX = IW'(pcpm_pkg::SLOT_IDX_BASE);

  // Preload address of a storage index
  function automatic logic [7:0] wordAddr(input logic [IW-1:0] idx);
    logic [7:0] slotOfs;
    slotOfs = 8'(idx - SLOT_IDX) * pcpm_pkg::SLOT_STRIDE;
    if (idx < SLOT_IDX) begin
      wordAddr = pcpm_pkg::PM_BASE_ADDR + 8'(idx);
    end else begin
      wordAddr = pcpm_pkg::SLOT_BASE_ADDR + slotOfs;
    end
  endfunction

  pcpm_pkg::pcpm_state_t state_reg;
  pcpm_pkg::pcpm_state_t state_next;
  logic [IW-1:0]  ldIdx_reg;
  logic [IW-1:0]  ldIdx_next;
  logic [pcpm_pkg::NUM_WORDS-1:0] loaded_reg;
  logic           pldReq_reg;
  logic [7:0]     pldAddr_reg;
  logic           loadDone_reg;

  // Stage 1 of a read
  logic           s1Valid_reg;
  logic [11:0]    s1Offset_reg;
  logic [2:0]     s1Port_reg;
  logic           s1Ld0_reg;
  logic           s1LdB_reg;
  logic           s1Okay_reg;
  logic           s1IsCtrl_reg;

  // Stage 2 (outputs)
  logic           cfgRdValid_reg;
  logic [31:0]    cfgRdData_reg;
  logic           cfgRdHit_reg;

  wire            wordTaken = pldReq_reg && pldAck;
  wire            lastWord  = ldIdx_reg == LAST_IDX;
  wire            portOkay  = cfgPort < 3'(pcpm_pkg::NUM_PORTS);
  wire            isCtrl    = cfgOffset == pcpm_pkg::OFS_PM_CTRL;
  wire            rdTaken   = cfgRdEn && loadDone_reg;
  wire [IW-1:0]   idx0      = IW'({cfgPort, 1'b0});
  wire [IW-1:0]   idxB      = isCtrl ? IW'({cfgPort, 1'b1})
                                     : SLOT_IDX + IW'(cfgPort);
  wire [15:0]     memA;
  wire [15:0]     memB;
  wire [15:0]     effW0;
  wire [15:0]     effWB;
  wire [15:0]     defB;
  wire [31:0]     mapValue;
  wire            mapHit;

  // Load walk: power pairs first, then one slot word per port
  always_comb begin
    state_next = state_reg;
    ldIdx_next = ldIdx_reg;
    case (state_reg)
      pcpm_pkg::PCPM_IDLE: begin
        state_next = pcpm_pkg::PCPM_LOAD;
        ldIdx_next = '0;
      end
      pcpm_pkg::PCPM_LOAD: begin
        if (wordTaken && lastWord) begin
          state_next = pcpm_pkg::PCPM_DONE;
        end else if (wordTaken) begin
          ldIdx_next = ldIdx_reg + IW'(1);
        end
      end
      pcpm_pkg::PCPM_DONE: begin
        state_next = pcpm_pkg::PCPM_DONE;
      end
      default: begin
        state_next = pcpm_pkg::PCPM_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg    <= pcpm_pkg::PCPM_IDLE;
      ldIdx_reg    <= '0;
      loaded_reg   <= '0;
      pldReq_reg   <= 1'b0;
      pldAddr_reg  <= 8'h00;
      loadDone_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      ldIdx_reg    <= ldIdx_next;
      pldReq_reg   <= state_next == pcpm_pkg::PCPM_LOAD;
      pldAddr_reg  <= wordAddr(ldIdx_next);
      loadDone_reg <= state_next == pcpm_pkg::PCPM_DONE;
      if (wordTaken && pldPresent) begin
        loaded_reg[ldIdx_reg] <= 1'b1;
      end
    end
  end

  pcpm_word_mem #(
    .WIDTH (16),
    .DEPTH (pcpm_pkg::NUM_WORDS)
  ) u_mem (
    .mclk    (mclk),
    .wrEn    (wordTaken && pldPresent),
    .wrAddr  (ldIdx_reg),
    .wrData  (pldData),
    .rdAddrA (idx0),
    .rdAddrB (idxB),
    .rdDataA (memA),
    .rdDataB (memB)
  );

  // Stage 1 captures which words really were loaded
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1Valid_reg  <= 1'b0;
      s1Offset_reg <= 12'h000;
      s1Port_reg   <= 3'h0;
      s1Ld0_reg    <= 1'b0;
      s1LdB_reg    <= 1'b0;
      s1Okay_reg   <= 1'b0;
      s1IsCtrl_reg <= 1'b0;
    end else begin
      s1Valid_reg  <= rdTaken;
      s1Offset_reg <= cfgOffset;
      s1Port_reg   <= cfgPort;
      s1Okay_reg   <= portOkay;
      s1IsCtrl_reg <= isCtrl;
      s1Ld0_reg    <= portOkay && loaded_reg[idx0];
      s1LdB_reg    <= portOkay && loaded_reg[idxB];
    end
  end

  // Unloaded words fall back so stale memory never shows
  assign defB  = s1IsCtrl_reg ? pcpm_pkg::PM_WORD1_RESET
                              : pcpm_pkg::SLOT_WORD_RESET;
  assign effW0 = s1Ld0_reg ? memA : pcpm_pkg::PM_WORD0_RESET;
  assign effWB = s1LdB_reg ? memB : defB;

  pcpm_field_map u_map (
    .offset (s1Offset_reg),
    .word0  (effW0),
    .wordB  (effWB),
    .value  (mapValue),
    .hit    (mapHit)
  );

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfgRdValid_reg <= 1'b0;
      cfgRdData_reg  <= 32'h0000_0000;
      cfgRdHit_reg   <= 1'b0;
    end else begin
      cfgRdValid_reg <= s1Valid_reg;
      cfgRdHit_reg   <= s1Valid_reg && mapHit && s1Okay_reg;
      if (s1Valid_reg) begin
        cfgRdData_reg <= (mapHit && s1Okay_reg) ? mapValue : 32'h0000_0000;
      end
    end
  end

  assign pldReq     = pldReq_reg;
  assign pldAddr    = pldAddr_reg;
  assign loadDone   = loadDone_reg;
  assign cfgRdValid = cfgRdValid_reg;
  assign cfgRdData  = cfgRdData_reg;
  assign cfgRdHit   = cfgRdHit_reg;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Offset of the answer now on the outputs
  logic [11:0] s2Offset_reg;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s2Offset_reg <= 12'h000;
    end else begin
      s2Offset_reg <= s1Offset_reg;
    end
  end

  wire rdHit  = cfgRdValid && cfgRdHit;
  wire wasCap = s2Offset_reg == pcpm_pkg::OFS_PM_CAP;
  wire wasCtl = s2Offset_reg == pcpm_pkg::OFS_PM_CTRL;

  sequence s_accept;
    cfgRdEn && loadDone;
  endsequence
  sequence s_answer;
    !cfgRdValid ##1 cfgRdValid;
  endsequence

  property p_nsr_port2;
    rdHit && wasCtl && $past(s1Port_reg) == 3'h2
      |-> cfgRdData[3] == $past(effW0[0]);
  endproperty
  a_nsr_port2: assert property (p_nsr_port2)
    else $error("port 2 skip-reset bit wrong");
  property p_aux;
    rdHit && wasCap |-> cfgRdData[24:22] == $past(effW0[3:1]);
  endproperty
  a_aux: assert property (p_aux)
    else $error("aux current field wrong");
  property p_d1;
    rdHit && wasCap |-> cfgRdData[25] == $past(effW0[4]);
  endproperty
  a_d1: assert property (p_d1)
    else $error("D1 support bit wrong");
  property p_d2;
    rdHit && wasCap |-> cfgRdData[26] == $past(effW0[5]);
  endproperty
  a_d2: assert property (p_d2)
    else $error("D2 support bit wrong");
  property p_wake;
    rdHit && wasCap |-> cfgRdData[29:28] == $past(effW0[7:6]);
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake support bits wrong");
  property p_data;
    rdHit && wasCtl |-> cfgRdData[31:24] == $past(effWB[15:8]);
  endproperty
  a_data: assert property (p_data)
    else $error("data byte wrong");
  property p_pm_hi_addr;
    pldReq && ldIdx_reg >= IW'(4) && ldIdx_reg < SLOT_IDX
      |-> pldAddr == 8'h54 + 8'(ldIdx_reg - IW'(4));
  endproperty
  a_pm_hi_addr: assert property (p_pm_hi_addr)
    else $error("port 2-5 word address wrong");
  property p_slot_clk;
    rdHit && $past(s1Offset_reg) == pcpm_pkg::OFS_SLOT_CLK
      |-> cfgRdData[28] == $past(effWB[1]) && cfgRdData[27:0] == 28'h0;
  endproperty
  a_slot_clk: assert property (p_slot_clk)
    else $error("slot clock bit wrong");
  property p_dsi;
    rdHit && wasCap |-> cfgRdData[21] == $past(effWB[2]);
  endproperty
  a_dsi: assert property (p_dsi)
    else $error("init-required bit wrong");
  property p_lpc;
    rdHit && $past(s1Offset_reg) == pcpm_pkg::OFS_LPC_GROUP
      |-> cfgRdData == {27'h0, $past(effWB[3]), 4'h0};
  endproperty
  a_lpc: assert property (p_lpc)
    else $error("channel group bit wrong");
  property p_pnum;
    rdHit && $past(s1Offset_reg) == pcpm_pkg::OFS_PORT_NUM
      |-> cfgRdData[26:24] == $past(effWB[6:4]);
  endproperty
  a_pnum: assert property (p_pnum)
    else $error("port number wrong");
  property p_tcmap;
    rdHit && $past(s1Offset_reg) == pcpm_pkg::OFS_VC0_MAP
      |-> cfgRdData[7:1] == $past(effWB[15:9]) && !cfgRdData[0];
  endproperty
  a_tcmap: assert property (p_tcmap)
    else $error("class map wrong");
  property p_pm_lo_addr;
    pldReq && ldIdx_reg < IW'(4) |-> pldAddr == 8'h50 + 8'(ldIdx_reg);
  endproperty
  a_pm_lo_addr: assert property (p_pm_lo_addr)
    else $error("port 0-1 word address wrong");
  property p_read_timing;
    s_accept ##0 !cfgRdValid ##0 !s1Valid_reg |-> ##1 s_answer;
  endproperty
  a_read_timing: assert property (p_read_timing)
    else $error("read answer not two cycles after accept");
  property p_no_early_read;
    cfgRdValid |-> loadDone && !pldReq;
  endproperty
  a_no_early_read: assert property (p_no_early_read)
    else $error("read answered before loading ended");
endmodule
`default_nettype wire

// [tb/pcpm_pld_model.sv]
// Behavioural preload word source for the loader bench.
// Assumes the bench fills mem and present before reset is released.
`default_nettype none
module pcpm_pld_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Request side
  input  wire logic        pldReq,
  input  wire logic [7:0]  pldAddr,
  input  wire logic [3:0]  waitCycles,
  // Answer side
  output logic             pldAck,
  output logic [15:0]      pldData,
  output logic             pldPresent
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem     [0:255];
  logic        present [0:255];
  logic [3:0]  cnt;

  // Data lines toggle outside an ack so stale values never look valid
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pldAck     <= 1'b0;
      pldData    <= 16'h5a5a;
      pldPresent <= 1'b0;
      cnt        <= 4'h0;
    end else if (pldAck) begin
      pldAck     <= 1'b0;
      pldData    <= ~pldData;
      pldPresent <= ~pldPresent;
      cnt        <= 4'h0;
    end else if (pldReq && cnt >= waitCycles) begin
      pldAck     <= 1'b1;
      pldData    <= mem[pldAddr];
      pldPresent <= present[pldAddr];
    end else begin
      cnt        <= pldReq ? cnt + 4'h1 : 4'h0;
      pldData    <= ~pldData;
      pldPresent <= ~pldPresent;
    end
  end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the preload loader and its read port.
// Assumes the design answers reads two edges after they are taken.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [2:0]  port;
    logic [11:0] off;
    logic [31:0] exp;
    logic        hit;
    int          due;
  } pcpm_row_t;

  logic        mclk, rstn, pldReq, pldAck, pldPresent, cfgRdEn;
  logic        cfgRdValid, cfgRdHit, loadDone;
  logic [7:0]  pldAddr;
  logic [15:0] pldData;
  logic [2:0]  cfgPort;
  logic [11:0] cfgOffset;
  logic [31:0] cfgRdData;
  logic [3:0]  waitCycles;
  int          num_errors, num_checks, seqIdx;
  int          cyc = 0;
  logic [15:0] pmw [12];
  logic [15:0] slw [6];
  logic        pmOk [12];
  logic        slOk [6];
  logic [11:0] offs [7] = '{12'h040, 12'h044, 12'h0cc, 12'h0d0,
                            12'h144, 12'h154, 12'h0c0};
  pcpm_row_t   rows [$];
  pcpm_row_t   pend [$];
  pcpm_row_t   mr;

  pcpm_loader i_pcpm_loader (.mclk(mclk), .rstn(rstn), .pldReq(pldReq),
    .pldAddr(pldAddr), .pldAck(pldAck), .pldData(pldData),
    .pldPresent(pldPresent), .cfgRdEn(cfgRdEn), .cfgPort(cfgPort),
    .cfgOffset(cfgOffset), .cfgRdValid(cfgRdValid), .cfgRdData(cfgRdData),
    .cfgRdHit(cfgRdHit), .loadDone(loadDone));
  pcpm_pld_model i_model (.mclk(mclk), .rstn(rstn), .pldReq(pldReq),
    .pldAddr(pldAddr), .waitCycles(waitCycles), .pldAck(pldAck),
    .pldData(pldData), .pldPresent(pldPresent));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic chkBit(string name, logic exp, logic got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chkVal(string name, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Absent words fall back to zero, as the loader keeps its defaults
  function automatic logic [31:0] image(int p, logic [11:0] off);
    logic [15:0] a, b, s;
    logic [31:0] v;
    v = 32'h0000_0000;
    if (p > 5) return v;
    a = pmOk[2*p] ? pmw[2*p] : 16'h0000;
    b = pmOk[2*p+1] ? pmw[2*p+1] : 16'h0000;
    s = slOk[p] ? slw[p] : 16'h0000;
    case (off)
      12'h040: begin
        v[24:22] = a[3:1];
        v[25]    = a[4];
        v[26]    = a[5];
        v[29:28] = a[7:6];
        v[21]    = s[2];
      end
      12'h044: begin
        v[3]     = a[0];
        v[31:24] = b[15:8];
      end
      12'h0d0: v[28]    = s[1];
      12'h144: v[4]     = s[3];
      12'h0cc: v[26:24] = s[6:4];
      12'h154: v[7:1]   = s[15:9];
      default: ;
    endcase
    return v;
  endfunction

  // Preload order seen at the link, one entry per acked word
  always @(posedge mclk or negedge rstn) begin
    if (!rstn)
      seqIdx <= 0;
    else if (pldReq === 1'b1 && pldAck === 1'b1) begin
      chkVal("pldAddr", seqIdx < 12 ? 32'h50 + seqIdx :
             32'h60 + 2 * (seqIdx - 12), {24'h0, pldAddr});
      seqIdx <= seqIdx + 1;
    end
  end

  always @(posedge mclk) cyc <= cyc + 1;

  // Read answers: due cycle gives a pulse, every other cycle none
  always @(negedge mclk) begin
    if (rstn === 1'b1) begin
      if (pend.size() > 0 && pend[0].due == cyc) begin
        mr = pend.pop_front();
        chkBit("cfgRdValid", 1'b1, cfgRdValid);
        chkBit("cfgRdHit", mr.hit, cfgRdHit);
        case (mr.off)
          12'h040: begin
            chkVal("cap40", mr.exp, cfgRdData);
            chkBit("d2cap40", mr.exp[26], cfgRdData[26]);
            chkBit("wake40", mr.exp[29], cfgRdData[29]);
            chkBit("dsi40", mr.exp[21], cfgRdData[21]);
          end
          12'h044: begin
            chkVal("ctl44", mr.exp, cfgRdData);
            chkBit("nsr44", mr.exp[3], cfgRdData[3]);
          end
          12'h0cc: chkVal("pnumCC", mr.exp, cfgRdData);
          12'h0d0: chkVal("clkD0", mr.exp, cfgRdData);
          12'h144: chkVal("grp144", mr.exp, cfgRdData);
          12'h154: chkVal("map154", mr.exp, cfgRdData);
          default: chkVal("unmapped", mr.exp, cfgRdData);
        endcase
      end else
        chkBit("cfgRdValid", 1'b0, cfgRdValid);
    end
  end

  task automatic rdIssue(logic [2:0] p, logic [11:0] off, logic taken);
    cfgRdEn   = 1'b1;
    cfgPort   = p;
    cfgOffset = off;
    if (taken)
      pend.push_back('{p, off, image(p, off), p < 6 && off != 12'h0c0,
                       cyc + 2});
    @(negedge mclk);
  endtask

  task automatic chkReset();
    chkBit("pldReq", 1'b0, pldReq);
    chkBit("loadDone", 1'b0, loadDone);
    chkVal("cfgRdData", 32'h0, cfgRdData);
  endtask

  task automatic waitLoad(string name);
    for (int k = 0; k < 400 && loadDone !== 1'b1; k++) @(negedge mclk);
    chkBit("loadDone", 1'b1, loadDone);
    chkBit("pldReq", 1'b0, pldReq);
    chkVal("wordCount", 32'd18, seqIdx);
    $display("test %s done", name);
  endtask

  // Back-to-back reads of every port and offset, one per cycle
  task automatic runRows(string name);
    foreach (rows[i]) rdIssue(rows[i].port, rows[i].off, 1'b1);
    cfgRdEn = 1'b0;
    repeat (4) @(negedge mclk);
    chkVal("pending", 32'h0, pend.size());
    $display("test %s done", name);
  endtask

  initial begin
    num_errors = 0;
    num_checks = 0;
    rstn       = 1'b0;
    cfgRdEn    = 1'b0;
    cfgPort    = 3'h0;
    cfgOffset  = 12'h000;
    waitCycles = 4'h0;
    for (int i = 0; i < 256; i++) begin
      i_model.mem[i]     = 16'(16'hdead ^ i);
      i_model.present[i] = 1'b1;
    end
    // One power data word and one slot word left absent
    for (int i = 0; i < 12; i++) begin
      pmw[i]  = 16'(16'h1357 * (i + 1) ^ (i[0] ? 16'hffff : 16'h0000));
      pmOk[i] = (i != 7);
      i_model.mem[8'h50 + i]     = pmw[i];
      i_model.present[8'h50 + i] = pmOk[i];
    end
    for (int p = 0; p < 6; p++) begin
      slw[p]  = 16'(16'hc3a5 ^ (p * 16'h2b6d));
      slOk[p] = (p != 5);
      i_model.mem[8'h60 + 2 * p]     = slw[p];
      i_model.present[8'h60 + 2 * p] = slOk[p];
    end
    for (int p = 0; p < 8; p++)
      foreach (offs[j])
        rows.push_back('{3'(p), offs[j], 32'h0, 1'b0, 0});
    repeat (6) @(negedge mclk);
    chkReset();
    $display("test reset done");
    rstn = 1'b1;
    @(negedge mclk);
    chkBit("pldReq", 1'b1, pldReq);
    chkVal("pldAddr", 32'h50, {24'h0, pldAddr});
    rdIssue(3'h2, 12'h040, 1'b0);
    cfgRdEn = 1'b0;
    waitLoad("fast load");
    runRows("read map");
    waitCycles = 4'h3;
    // Restart, then cut the slow load part way through
    rstn = 1'b0;
    @(negedge mclk);
    rstn = 1'b1;
    repeat (10) @(negedge mclk);
    rstn = 1'b0;
    pend.delete();
    repeat (2) @(negedge mclk);
    chkReset();
    rstn = 1'b1;
    waitLoad("slow reload");
    runRows("reread map");
    close_out();
  end

  // Expected run is well under a thousand cycles; forty times that
  initial begin
    #(20 * 40000);
    num_errors++;
    $display("ERROR watchdog expected finish seen timeout");
    close_out();
  end
endmodule
`default_nettype wire
